/* File: term_stream_pkg.sv */
// codes, field positions, reset values and states of the terminal stream interpreter
// assumes a single clock domain; no timing is defined for the stream
package term_stream_pkg;

  // character codes: format effectors, other controls and printable bounds
  localparam logic [7:0] C_NUL      = 8'h00;
  localparam logic [7:0] C_ETX      = 8'h03;
  localparam logic [7:0] C_BEL      = 8'h07;
  localparam logic [7:0] C_BS       = 8'h08;
  localparam logic [7:0] C_HT       = 8'h09;
  localparam logic [7:0] C_LF       = 8'h0a;
  localparam logic [7:0] C_VT       = 8'h0b;
  localparam logic [7:0] C_FF       = 8'h0c;
  localparam logic [7:0] C_CR       = 8'h0d;
  localparam logic [7:0] C_SUB      = 8'h1a;
  localparam logic [7:0] C_SPACE    = 8'h20;
  localparam logic [7:0] C_DEL      = 8'h7f;

  // in-band control signals
  localparam logic [7:0] C_MARK     = 8'h80;
  localparam logic [7:0] C_BREAK    = 8'h81;
  localparam logic [7:0] C_NOP      = 8'h82;
  localparam logic [7:0] C_NO_ECHO  = 8'h83;
  localparam logic [7:0] C_ECHO     = 8'h84;
  localparam logic [7:0] C_HIDE     = 8'h85;
  localparam logic [7:0] C_SET_STD  = 8'ha0;
  localparam logic [7:0] C_SET_TRN  = 8'ha1;
  localparam logic [7:0] C_SET_ALT  = 8'ha2;

  // bit positions and width of the printer effect vector
  localparam int FX_BEL   = 0;
  localparam int FX_BS    = 1;
  localparam int FX_HT    = 2;
  localparam int FX_LF    = 3;
  localparam int FX_VT    = 4;
  localparam int FX_FF    = 5;
  localparam int FX_CR    = 6;
  localparam int FX_W     = 7;

  // local line buffer
  localparam int BUF_DEPTH = 16;
  localparam int BUF_AW    = 4;

  // reset values
  localparam logic SRV_ECHO_RST = 1'b0;
  localparam logic RMT_ECHO_RST = 1'b0;
  localparam logic HIDE_RST     = 1'b0;

  typedef enum logic [2:0] {
    RX_RUN  = 3'b001,
    RX_HOLD = 3'b010,
    RX_SCAN = 3'b100
  } rx_state_t;

  typedef enum logic [2:0] {
    CS_STD = 3'b001,
    CS_TRN = 3'b010,
    CS_ALT = 3'b100
  } code_set_t;

endpackage : term_stream_pkg

/* File: term_stream_interp.sv */
// terminal stream interpreter: receive decoder, mark/interrupt discard, keyboard path
// assumes the far side keeps its own signalling rules; one clock, inputs synchronous
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////////////
// Contract
// - bytes 0-127 are characters, 128-255 signals
// - cr returns margin, lf advances one line
// - bs steps back, ht to next tab
// - vt to vertical tab, ff to next page
// - bel raises alert, nul does nothing
// - other control codes cause no printer action
// - line ends are sent as cr then lf
// - break is attention at server, ignored at user; the code raises rev_break_evt at the user
// - data mark is a position marker for synch
// - nop accepted anywhere, no action
// - no-echo request, or server echo-off declaration
// - echo request, or server echo-on declaration
// - hide input suppresses local echo until no-echo
// - server stalls at mark until interrupt arrives
// - server on interrupt scans to mark, acts breaks
// - user discards through mark after interrupt
// - codes 160-162 select code sets
// - transmit-now sends all buffered input
// - suppress-eol flushes and drops following line end
// - server handles signals, assumes user echoes
// - user may send break, synch, echo, no-echo
module term_stream_interp
  import term_stream_pkg::*;
(
  input  wire logic                       ref_clk,
  input  wire logic                       nrst,
  input  wire logic                       is_server,
  input  wire logic                       line_mode,
  input  wire logic                       rx_valid,
  input  wire logic [7:0]                 rx_data,
  output logic                            rx_ready,
  input  wire logic                       ins_in,
  output logic                            ch_valid,
  output logic [7:0]                      ch_data,
  output logic [term_stream_pkg::FX_W-1:0] fx_evt,
  output logic                            break_evt,
  output logic                            rev_break_evt,
  output logic                            srv_echo,
  output logic                            remote_echo,
  output logic                            hide_input,
  output logic [2:0]                      code_set,
  output logic                            discarding,
  input  wire logic                       key_valid,
  input  wire logic [7:0]                 key_data,
  output logic                            key_ready,
  input  wire logic                       send_now,
  input  wire logic                       suppress_eol,
  input  wire logic                       send_break,
  input  wire logic                       send_synch,
  input  wire logic                       ask_echo,
  input  wire logic                       ask_no_echo,
  output logic                            echo_valid,
  output logic [7:0]                      echo_data,
  output logic                            tx_valid,
  output logic [7:0]                      tx_data,
  input  wire logic                       tx_ready,
  output logic                            ins_out
);
  import term_stream_pkg::*;

  //////////////////////////////////////////////////////////////////////////////////
  // reset release

  logic       rst_meta_r;
  logic       rst_sync_r;
  wire        rst_n = rst_sync_r;

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////
  // receive decode

  rx_state_t            st_r, st_nxt;
  code_set_t            cs_r, cs_nxt;
  logic                 srv_echo_r, rmt_echo_r, hide_r;
  logic                 ch_valid_r, brk_r, rbrk_r;
  logic [7:0]           ch_r;
  logic [FX_W-1:0]      fx_r, fx_nxt;
  logic                 reply_r;
  logic [7:0]           reply_code_r;

  assign rx_ready = (st_r != RX_HOLD);
  wire rx_take  = rx_valid && rx_ready;
  wire std_set  = (cs_r == CS_STD);
  wire is_sig   = rx_data[7];
  wire run_take = rx_take && (st_r == RX_RUN);
  wire mark_hit = rx_take && std_set && (rx_data == C_MARK);
  wire sig_take = run_take && std_set && is_sig;
  wire data_run = run_take && (!std_set || !is_sig);
  wire user     = !is_server;

  // a break-type byte met while scanning still reaches the server
  wire scan_brk = rx_take && (st_r == RX_SCAN) && is_server &&
                  ((std_set && rx_data == C_BREAK) ||
                   rx_data == C_ETX || rx_data == C_SUB);
  wire brk_sig  = sig_take && rx_data == C_BREAK;
  wire got_noe  = sig_take && rx_data == C_NO_ECHO;
  wire got_echo = sig_take && rx_data == C_ECHO;
  wire got_hide = sig_take && rx_data == C_HIDE && user;
  wire set_hit  = run_take && (rx_data == C_SET_STD ||
                  (std_set && (rx_data == C_SET_TRN || rx_data == C_SET_ALT)));

  // escaped sets carry undefined signals, so bytes there other than set-standard pass as data
  wire graphic  = (rx_data >= C_SPACE) && (rx_data < C_DEL);
  wire ch_out   = (data_run && !set_hit &&
                   (!std_set || is_server || graphic)) ||
                  (scan_brk && !rx_data[7]);

  always_comb
  begin
    st_nxt = st_r;
    case (st_r)
      RX_RUN:
      begin
        if (ins_in && mark_hit)
          st_nxt = RX_RUN;
        else if (ins_in)
          st_nxt = RX_SCAN;
        else if (mark_hit)
          st_nxt = RX_HOLD;
      end
      RX_HOLD:
      begin
        if (ins_in)
          st_nxt = RX_RUN;
      end
      RX_SCAN:
      begin
        if (mark_hit)
          st_nxt = RX_RUN;
      end
      default:
        st_nxt = RX_RUN;
    endcase
  end

  always_comb
  begin
    cs_nxt = cs_r;
    if (set_hit && rx_data == C_SET_STD)
      cs_nxt = CS_STD;
    else if (set_hit && rx_data == C_SET_TRN)
      cs_nxt = CS_TRN;
    else if (set_hit && rx_data == C_SET_ALT)
      cs_nxt = CS_ALT;
  end

  // printer effects exist only at the user end, in the standard set
  wire fx_ok = data_run && std_set && user;
  always_comb
  begin
    fx_nxt         = '0;
    fx_nxt[FX_CR]  = fx_ok && rx_data == C_CR;
    fx_nxt[FX_LF]  = fx_ok && rx_data == C_LF;
    fx_nxt[FX_BS]  = fx_ok && rx_data == C_BS;
    fx_nxt[FX_HT]  = fx_ok && rx_data == C_HT;
    fx_nxt[FX_VT]  = fx_ok && rx_data == C_VT;
    fx_nxt[FX_FF]  = fx_ok && rx_data == C_FF;
    fx_nxt[FX_BEL] = fx_ok && rx_data == C_BEL;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r       <= RX_RUN;
      cs_r       <= CS_STD;
      fx_r       <= '0;
      ch_valid_r <= 1'b0;
      ch_r       <= C_NUL;
      brk_r      <= 1'b0;
      rbrk_r     <= 1'b0;
    end
    else
    begin
      st_r       <= st_nxt;
      cs_r       <= cs_nxt;
      fx_r       <= fx_nxt;
      ch_valid_r <= ch_out;
      if (ch_out)
        ch_r <= rx_data;
      brk_r      <= (brk_sig && is_server) || scan_brk;
      rbrk_r     <= brk_sig && user;
    end
  end

  // echo state; nop and unknown signals fall through with no effect
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      srv_echo_r <= SRV_ECHO_RST;
      rmt_echo_r <= RMT_ECHO_RST;
      hide_r     <= HIDE_RST;
    end
    else
    begin
      if (is_server && got_echo)
        srv_echo_r <= 1'b1;
      else if (is_server && got_noe)
        srv_echo_r <= 1'b0;
      if (user && got_echo)
        rmt_echo_r <= 1'b1;
      else if (user && got_noe)
        rmt_echo_r <= 1'b0;
      if (got_hide)
        hide_r <= 1'b1;
      else if (user && got_noe)
        hide_r <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////
  // keyboard line buffer

  logic [7:0]        buf_mem [BUF_DEPTH];
  logic [BUF_AW:0]   wr_ptr_r, rd_ptr_r;
  logic              flush_r, skip_r;
  logic              echo_valid_r;
  logic [7:0]        echo_r;
  logic              ctl_pend_r;
  logic [7:0]        ctl_code_r;
  logic              ins_r;
  logic              hold_buf_r;

  wire buf_empty = (wr_ptr_r == rd_ptr_r);
  wire buf_full  = (wr_ptr_r[BUF_AW] != rd_ptr_r[BUF_AW]) &&
                   (wr_ptr_r[BUF_AW-1:0] == rd_ptr_r[BUF_AW-1:0]);
  assign key_ready = !buf_full;
  wire key_take  = key_valid && key_ready;

  // after suppress-eol the next cr, then lf, are swallowed
  wire key_skip  = key_take && skip_r &&
                   (key_data == C_CR || key_data == C_LF);
  wire key_store = key_take && !key_skip;
  wire flush_req = send_now || suppress_eol ||
                   (key_store && key_data == C_LF) || buf_full;
  wire drain_ok  = !line_mode || flush_r || flush_req;

  // local echo only while the server is not echoing and input is not hidden
  wire echo_now  = key_store && user && !rmt_echo_r && !hide_r;

  // control bytes go ahead of buffered data; one may wait at a time
  wire user_ctl  = user && (send_break || send_synch || ask_echo || ask_no_echo);
  wire srv_reply = is_server && (got_echo || got_noe);
  // a buffered byte already on offer keeps the link until it is taken
  wire tx_ctl    = ctl_pend_r && !hold_buf_r;
  assign tx_valid = tx_ctl || (!buf_empty && drain_ok);
  assign tx_data  = tx_ctl ? ctl_code_r : buf_mem[rd_ptr_r[BUF_AW-1:0]];
  wire tx_take   = tx_valid && tx_ready;
  wire ctl_sent  = tx_take && tx_ctl;
  wire buf_sent  = tx_take && !tx_ctl;

  logic [7:0] ctl_sel;
  assign ctl_sel = srv_reply    ? rx_data :
                   send_break   ? C_BREAK :
                   send_synch   ? C_MARK  :
                   ask_echo     ? C_ECHO  :
                                  C_NO_ECHO;

  always_ff @(posedge ref_clk)
  begin
    if (key_store)
      buf_mem[wr_ptr_r[BUF_AW-1:0]] <= key_data;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      flush_r  <= 1'b0;
      skip_r   <= 1'b0;
    end
    else
    begin
      if (key_store)
        wr_ptr_r <= wr_ptr_r + 1'b1;
      if (buf_sent)
        rd_ptr_r <= rd_ptr_r + 1'b1;
      if (flush_req)
        flush_r <= 1'b1;
      else if (buf_empty)
        flush_r <= 1'b0;
      if (suppress_eol)
        skip_r <= 1'b1;
      else if (key_take && key_data != C_CR)
        skip_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      echo_valid_r <= 1'b0;
      echo_r       <= C_NUL;
      ctl_pend_r   <= 1'b0;
      ctl_code_r   <= C_NOP;
      ins_r        <= 1'b0;
      hold_buf_r   <= 1'b0;
    end
    else
    begin
      echo_valid_r <= echo_now;
      if (echo_now)
        echo_r <= key_data;
      if (!ctl_pend_r && (srv_reply || user_ctl))
      begin
        ctl_pend_r <= 1'b1;
        ctl_code_r <= ctl_sel;
      end
      else if (ctl_sent)
        ctl_pend_r <= 1'b0;
      // the interrupt follows the mark so the far end finds it in the stream
      ins_r <= ctl_sent && ctl_code_r == C_MARK;
      hold_buf_r <= tx_valid && !tx_ctl && !tx_ready;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////
  // outputs

  assign ch_valid      = ch_valid_r;
  assign ch_data       = ch_r;
  assign fx_evt        = fx_r;
  assign break_evt     = brk_r;
  assign rev_break_evt = rbrk_r;
  assign srv_echo      = srv_echo_r;
  assign remote_echo   = rmt_echo_r;
  assign hide_input    = hide_r;
  assign code_set      = cs_r;
  assign discarding    = (st_r == RX_SCAN);
  assign echo_valid    = echo_valid_r;
  assign echo_data     = echo_r;
  assign ins_out       = ins_r;

endmodule : term_stream_interp

/* File: term_stream_check_sva.sv */
// assertions on the ports of the terminal stream interpreter
// assumes the bench makes no request before the third edge after reset
`timescale 1ns/1ps
module term_stream_check
  import term_stream_pkg::*;
(
  input wire logic            ref_clk,
  input wire logic            nrst,
  input wire logic            is_server,
  input wire logic            rx_valid,
  input wire logic [7:0]      rx_data,
  input wire logic            rx_ready,
  input wire logic            ins_in,
  input wire logic [FX_W-1:0] fx_evt,
  input wire logic            break_evt,
  input wire logic            rev_break_evt,
  input wire logic            hide_input,
  input wire logic [2:0]      code_set,
  input wire logic            discarding,
  input wire logic            tx_valid,
  input wire logic [7:0]      tx_data,
  input wire logic            tx_ready,
  input wire logic            ins_out
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////////////
  // a byte taken in the standard set, outside discard, with no interrupt beside it
  wire take_w = rx_valid && rx_ready;
  wire run_w  = take_w && code_set == CS_STD && !discarding && !ins_in;
  sequence mark_taken_s;
    run_w && rx_data == C_MARK;
  endsequence
  sequence ins_seen_s;
    !rx_ready && ins_in;
  endsequence
  sequence cr_user_s;
    run_w && !is_server && rx_data == C_CR;
  endsequence
  sequence brk_srv_s;
    take_w && is_server && code_set == CS_STD && rx_data == C_BREAK;
  endsequence
  sequence brk_user_s;
    run_w && !is_server && rx_data == C_BREAK;
  endsequence
  sequence noe_user_s;
    run_w && !is_server && rx_data == C_NO_ECHO;
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  hold_at_mark_a: assert property (mark_taken_s |=> !rx_ready)
    else $error("input not stalled after data mark");
  stall_keeps_a: assert property (!rx_ready && !ins_in |=> !rx_ready)
    else $error("stall ended without interrupt");
  resume_on_ins_a: assert property (ins_seen_s |=> rx_ready)
    else $error("stall kept after interrupt");
  cr_margin_a: assert property (cr_user_s |=> fx_evt[FX_CR] && $onehot(fx_evt))
    else $error("carriage return effect missing");
  srv_break_a: assert property (brk_srv_s |=> break_evt)
    else $error("server break missing");
  rev_break_a: assert property (brk_user_s |=> rev_break_evt && !break_evt)
    else $error("reverse break wrong");
  hide_clear_a: assert property (noe_user_s |=> !hide_input)
    else $error("hide kept after no echo");
  set_escape_a: assert property (run_w && rx_data == C_SET_TRN |=> code_set == CS_TRN)
    else $error("transparent set not selected");
  tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("tx byte dropped while stalled");
  ins_follow_a: assert property (tx_valid && tx_ready && tx_data == C_MARK |=> ins_out)
    else $error("interrupt not sent after mark");
endmodule : term_stream_check

bind term_stream_interp term_stream_check u_chk (.ref_clk(ref_clk), .nrst(nrst),
  .is_server(is_server), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
  .ins_in(ins_in), .fx_evt(fx_evt), .break_evt(break_evt), .rev_break_evt(rev_break_evt),
  .hide_input(hide_input), .code_set(code_set), .discarding(discarding),
  .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .ins_out(ins_out));

/* File: term_stream_remote.sv */
// far-side sink for the transmit stream: stalls two cycles of three
// assumes one clock; ready moves on the falling edge, away from sampling
`timescale 1ns/1ps
module term_stream_remote
(
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready,
  output logic [7:0]      got_count,
  output logic [7:0]      got_last
);
  logic [1:0] phase_r;
  initial tx_ready = 1'b0;
  initial phase_r = 2'h0;
  // regular two-cycle stalls so held bytes really get tested
  always @(negedge ref_clk)
  begin
    phase_r  <= (phase_r == 2'h2) ? 2'h0 : phase_r + 2'h1;
    tx_ready <= (phase_r == 2'h2);
  end
  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      got_count <= 8'h00;
      got_last  <= 8'h00;
    end
    else if (tx_valid && tx_ready)
    begin
      got_count <= got_count + 8'h01;
      got_last  <= tx_data;
    end
  end
endmodule : term_stream_remote

/* File: terminal_stream_control_interpreter_bench.sv */
// self-checking bench: stream bytes in, keyboard and signals out
// assumes the remote sink model stands on the transmit side
`timescale 1ns/1ps
module terminal_stream_control_interpreter_bench;
  import term_stream_pkg::*;
  logic ref_clk = 1'b0, nrst = 1'b0, is_server = 1'b0, line_mode = 1'b0;
  logic rx_valid = 1'b0, ins_in = 1'b0, key_valid = 1'b0, send_now = 1'b0;
  logic suppress_eol = 1'b0, send_break = 1'b0, send_synch = 1'b0;
  logic ask_echo = 1'b0, ask_no_echo = 1'b0;
  logic [7:0] rx_data = 8'h00, key_data = 8'h00;
  logic rx_ready, ch_valid, break_evt, rev_break_evt, srv_echo, remote_echo;
  logic hide_input, discarding, key_ready, echo_valid, tx_valid, tx_ready, ins_out;
  logic [7:0] ch_data, echo_data, tx_data, got_count, got_last;
  logic [FX_W-1:0] fx_evt;
  logic [2:0] code_set;
  int fail_count = 0, compares = 0;
  always #12.5 ref_clk = ~ref_clk;
  term_stream_interp dut (.ref_clk(ref_clk), .nrst(nrst), .is_server(is_server),
    .line_mode(line_mode), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
    .ins_in(ins_in), .ch_valid(ch_valid), .ch_data(ch_data), .fx_evt(fx_evt),
    .break_evt(break_evt), .rev_break_evt(rev_break_evt), .srv_echo(srv_echo),
    .remote_echo(remote_echo), .hide_input(hide_input), .code_set(code_set),
    .discarding(discarding), .key_valid(key_valid), .key_data(key_data),
    .key_ready(key_ready), .send_now(send_now), .suppress_eol(suppress_eol),
    .send_break(send_break), .send_synch(send_synch), .ask_echo(ask_echo),
    .ask_no_echo(ask_no_echo), .echo_valid(echo_valid), .echo_data(echo_data),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .ins_out(ins_out));
  term_stream_remote u_rem (.ref_clk(ref_clk), .nrst(nrst), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .got_count(got_count), .got_last(got_last));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  task automatic do_reset(input logic srv);
    nrst = 1'b0;
    is_server = srv;
    repeat (16) @(negedge ref_clk);
    nrst = 1'b1;
    repeat (3) @(negedge ref_clk);
  endtask : do_reset
  // outputs of the byte are settled at the negedge after it is taken
  task automatic rx_byte(input logic [7:0] b);
    @(negedge ref_clk);
    rx_valid = 1'b1;
    rx_data = b;
    @(negedge ref_clk);
    rx_valid = 1'b0;
  endtask : rx_byte
  task automatic key(input logic [7:0] b);
    @(negedge ref_clk);
    key_valid = 1'b1;
    key_data = b;
    @(negedge ref_clk);
    key_valid = 1'b0;
  endtask : key
  task automatic ins_pulse;
    @(negedge ref_clk);
    ins_in = 1'b1;
    @(negedge ref_clk);
    ins_in = 1'b0;
  endtask : ins_pulse
  task automatic ctl(input int k);
    @(negedge ref_clk);
    case (k)
      0: send_break = 1'b1;
      1: send_synch = 1'b1;
      2: ask_echo = 1'b1;
      3: ask_no_echo = 1'b1;
      4: send_now = 1'b1;
      default: suppress_eol = 1'b1;
    endcase
    @(negedge ref_clk);
    {send_break, send_synch, ask_echo, ask_no_echo, send_now, suppress_eol} = 6'h00;
  endtask : ctl
  task automatic wait_tx(input logic [7:0] n, input logic [7:0] last);
    for (int i = 0; i < 80 && got_count !== n; i++)
      @(negedge ref_clk);
    check("tx count", got_count, n);
    check("tx byte", got_last, last);
  endtask : wait_tx
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_format;
    logic [7:0] fmt[7] = '{C_CR, C_LF, C_BS, C_HT, C_VT, C_FF, C_BEL};
    int bits[7] = '{FX_CR, FX_LF, FX_BS, FX_HT, FX_VT, FX_FF, FX_BEL};
    logic [7:0] quiet[5] = '{C_NUL, 8'h05, C_SUB, C_DEL, C_NOP};
    for (int i = 0; i < 7; i++)
    begin
      rx_byte(fmt[i]);
      check("fx", 8'(fx_evt), 8'h01 << bits[i]);
    end
    for (int i = 0; i < 5; i++)
    begin
      rx_byte(quiet[i]);
      check("fx quiet", {ch_valid, 7'(fx_evt)}, 8'h00);
    end
    rx_byte(8'h41);
    check("char", {ch_valid, ch_data[6:0]}, 8'hc1);
    rx_byte(C_BREAK);
    check("rev break", {rev_break_evt, break_evt}, 8'h02);
  endtask : t_format
  task automatic t_sets;
    rx_byte(C_SET_TRN);
    check("set trn", code_set, CS_TRN);
    rx_byte(C_HIDE);
    check("raw byte", {ch_valid, hide_input}, 8'h02);
    rx_byte(C_SET_STD);
    check("set std", code_set, CS_STD);
    rx_byte(C_SET_ALT);
    check("set alt", code_set, CS_ALT);
    rx_byte(C_SET_STD);
    check("set back", code_set, CS_STD);
  endtask : t_sets
  task automatic t_user_synch;
    ins_pulse();
    check("discard on", discarding, 8'h01);
    rx_byte(8'h42);
    check("dropped", ch_valid, 8'h00);
    rx_byte(C_MARK);
    check("discard off", {discarding, rx_ready}, 8'h01);
  endtask : t_user_synch
  task automatic t_hide;
    rx_byte(C_HIDE);
    check("hide", hide_input, 8'h01);
    key(8'h70);
    check("hidden echo", echo_valid, 8'h00);
    wait_tx(8'h01, 8'h70);
    rx_byte(C_NO_ECHO);
    check("unhide", hide_input, 8'h00);
    key(8'h71);
    check("echo", {echo_valid, echo_data[6:0]}, 8'hf1);
    rx_byte(C_ECHO);
    check("remote echo", remote_echo, 8'h01);
    key(8'h72);
    check("no local echo", echo_valid, 8'h00);
    rx_byte(C_NO_ECHO);
    check("remote off", remote_echo, 8'h00);
  endtask : t_hide
  task automatic t_user_ctl;
    logic [7:0] code[4] = '{C_BREAK, C_MARK, C_ECHO, C_NO_ECHO};
    wait_tx(8'h03, 8'h72);
    for (int k = 0; k < 4; k++)
    begin
      ctl(k);
      wait_tx(8'h04 + 8'(k), code[k]);
      check("ins out", ins_out, 8'(k == 1));
    end
  endtask : t_user_ctl
  task automatic t_line;
    line_mode = 1'b1;
    key(8'h61);
    key(8'h62);
    repeat (6) @(negedge ref_clk);
    check("held", got_count, 8'h07);
    ctl(4);
    wait_tx(8'h09, 8'h62);
    key(8'h63);
    ctl(5);
    key(C_CR);
    key(C_LF);
    ctl(4);
    wait_tx(8'h0a, 8'h63);
    repeat (8) @(negedge ref_clk);
    check("no line end", got_count, 8'h0a);
    for (int i = 0; i < 16; i++)
      key(8'h30 + 8'(i));
    check("full", key_ready, 8'h00);
    wait_tx(8'h1a, 8'h3f);
    line_mode = 1'b0;
  endtask : t_line
  task automatic t_server;
    check("srv echo rst", srv_echo, 8'h00);
    rx_byte(C_MARK);
    repeat (4) @(negedge ref_clk);
    check("stalled", rx_ready, 8'h00);
    ins_pulse();
    check("resumed", rx_ready, 8'h01);
    ins_pulse();
    rx_byte(C_ETX);
    check("scan break", break_evt, 8'h01);
    rx_byte(C_MARK);
    check("scan end", discarding, 8'h00);
    rx_byte(C_BREAK);
    check("break", break_evt, 8'h01);
    rx_byte(C_ECHO);
    check("srv echo on", srv_echo, 8'h01);
    wait_tx(8'h01, C_ECHO);
    rx_byte(C_NO_ECHO);
    check("srv echo off", srv_echo, 8'h00);
    wait_tx(8'h02, C_NO_ECHO);
  endtask : t_server
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (4000) @(posedge ref_clk);
    fail_count++;
    give_verdict();
  end
  initial
  begin
    do_reset(1'b0);
    t_format();
    t_sets();
    t_user_synch();
    t_hide();
    t_user_ctl();
    t_line();
    do_reset(1'b1);
    t_server();
    give_verdict();
  end
endmodule : terminal_stream_control_interpreter_bench
